// ==== hw/overtemp_regs.vh ====
`ifndef OVERTEMP_REGS_VH
`define OVERTEMP_REGS_VH

// register indices, byte address is four times the index
`define IDX_FAULT_STATUS   8'h10
`define IDX_FET_CONTROL    8'h40
`define IDX_TEMP_THRESHOLD 8'h83
`define IDX_ALERT_MASK     8'h84
`define IDX_SCAN_CONTROL   8'h85
`define IDX_SAMPLE_CODES   8'h86

// field positions
`define FS_OVERTEMP_BIT    4
`define FC_CHG_EN_BIT      0
`define FC_DIS_EN_BIT      1
`define FC_CLEAR_ALL_BIT   6
`define TH_CHG_LO          3
`define TH_CHG_HI          5
`define TH_DIS_LO          11
`define TH_DIS_HI          13
`define SC_START_BIT       0
`define SC_BUSY_BIT        0
`define SC_FLAG_LO         8
`define SC_FLAG_HI         9

// reset values
`define FET_CONTROL_RST    16'h0000
`define TEMP_THRESHOLD_RST 16'h0000
`define ALERT_MASK_RST     16'h0003

// widths
`define CODE_W             8
`define LIMIT_PAD          5'h00
`define NUM_CH             2
`define CH_W               1
`define CH_LAST            1'h1
`define CH_FIRST           1'h0

`endif

// ==== hw/ot_compare.v ====
`timescale 1ns/1ps
`include "overtemp_regs.vh"

module ot_compare (
  input  wire                 i_clk_sys,
  input  wire                 i_reset,
  input  wire                 i_sample_valid,
  input  wire [`CODE_W-1:0]   i_code,
  input  wire [`CODE_W-1:0]   i_limit,
  output reg                  o_done_ff,
  output reg                  o_fault_ff
);

  // ntc: lower voltage means hotter, so below limit is a fault
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_done_ff  <= 1'b0;
      o_fault_ff <= 1'b0;
    end
    else
    begin
      o_done_ff  <= i_sample_valid;
      o_fault_ff <= i_sample_valid & (i_code < i_limit);
    end
  end

endmodule // ot_compare

// ==== hw/external_overtemp_detect.v ====
// Overview of operation
// - During scan-all, sample every external temperature input and compare to its threshold.
// - A reading below the programmed limit is an over-temperature fault (NTC).
// - On a fault set the fault flag and, if allowed, raise the alert output.
// - Two external inputs, each compared against its own independent threshold.
// - Charge and discharge limit fields in the threshold register are the references.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "overtemp_regs.vh"

module external_overtemp_detect (
  input  wire                 i_clk_sys,
  input  wire                 i_reset,
  input  wire [11:0]          i_avs_address,
  input  wire                 i_avs_read,
  input  wire                 i_avs_write,
  input  wire [31:0]          i_avs_writedata,
  input  wire [3:0]           i_avs_byteenable,
  output reg  [31:0]          o_avs_readdata,
  output reg                  o_avs_waitrequest,
  output reg                  o_adc_req,
  output reg  [`CH_W-1:0]     o_adc_channel,
  input  wire                 i_adc_done,
  input  wire [`CODE_W-1:0]   i_adc_code,
  output reg                  o_alert,
  output reg                  o_charge_switch_enable,
  output reg                  o_discharge_switch_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // scan states

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_REQ  = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_EVAL = 4'h8;

  reg  [3:0]              state_ff;
  reg  [3:0]              nxt_state;
  reg  [`CH_W-1:0]        chan_ff;
  reg  [`CH_W-1:0]        nxt_chan;
  reg  [15:0]             fet_control_ff;
  reg  [15:0]             temp_threshold_ff;
  reg  [15:0]             alert_mask_ff;
  reg  [`NUM_CH-1:0]      chan_flag_ff;
  reg  [`NUM_CH-1:0]      nxt_chan_flag;
  reg  [`CODE_W-1:0]      code_ff [0:`NUM_CH-1];
  reg  [`NUM_CH-1:0]      sample_valid_ff;
  wire [`NUM_CH-1:0]      cmp_done;
  wire [`NUM_CH-1:0]      cmp_fault;
  wire [`CODE_W-1:0]      limit [0:`NUM_CH-1];
  wire                    bus_req;
  wire                    bus_acc;
  wire                    wr_acc;
  wire [15:0]             wr_data16;
  wire                    start_scan;
  wire                    clear_all;
  reg  [15:0]             rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // register decode helpers

  function hit;
    input [11:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr[1:0] == 2'h0) & (addr[11:2] == {2'h0, idx});
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  be;
    begin
      merge16 = {be[1] ? new_val[15:8] : old_val[15:8],
                 be[0] ? new_val[7:0]  : old_val[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: waitrequest drops one cycle after a request is seen

  assign bus_req    = i_avs_read | i_avs_write;
  assign bus_acc    = bus_req & ~o_avs_waitrequest;
  assign wr_acc     = i_avs_write & ~o_avs_waitrequest;
  assign wr_data16  = i_avs_writedata[15:0];
  assign start_scan = wr_acc & hit(i_avs_address, `IDX_SCAN_CONTROL) & i_avs_byteenable[0]
                      & i_avs_writedata[`SC_START_BIT];
  assign clear_all  = wr_acc & hit(i_avs_address, `IDX_FET_CONTROL) & i_avs_byteenable[0]
                      & i_avs_writedata[`FC_CLEAR_ALL_BIT];

  always @*
  begin
    rd_mux = 16'h0000;
    if (hit(i_avs_address, `IDX_FAULT_STATUS))
      rd_mux[`FS_OVERTEMP_BIT] = |chan_flag_ff;
    else if (hit(i_avs_address, `IDX_FET_CONTROL))
      rd_mux = fet_control_ff;
    else if (hit(i_avs_address, `IDX_TEMP_THRESHOLD))
      rd_mux = temp_threshold_ff;
    else if (hit(i_avs_address, `IDX_ALERT_MASK))
      rd_mux = alert_mask_ff;
    else if (hit(i_avs_address, `IDX_SCAN_CONTROL))
    begin
      rd_mux[`SC_BUSY_BIT] = (state_ff != ST_IDLE);
      rd_mux[`SC_FLAG_HI:`SC_FLAG_LO] = chan_flag_ff;
    end
    else if (hit(i_avs_address, `IDX_SAMPLE_CODES))
      rd_mux = {code_ff[1], code_ff[0]};
  end

  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
      if (bus_req & o_avs_waitrequest)
        o_avs_readdata <= {16'h0000, rd_mux};
    end
  end

  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      fet_control_ff    <= `FET_CONTROL_RST;
      temp_threshold_ff <= `TEMP_THRESHOLD_RST;
      alert_mask_ff     <= `ALERT_MASK_RST;
    end
    else if (wr_acc)
    begin
      if (hit(i_avs_address, `IDX_FET_CONTROL))
      begin
        fet_control_ff <= merge16(fet_control_ff, wr_data16, i_avs_byteenable[1:0]);
        fet_control_ff[`FC_CLEAR_ALL_BIT] <= 1'b0;
      end
      if (hit(i_avs_address, `IDX_TEMP_THRESHOLD))
        temp_threshold_ff <= merge16(temp_threshold_ff, wr_data16, i_avs_byteenable[1:0]);
      if (hit(i_avs_address, `IDX_ALERT_MASK))
        alert_mask_ff <= merge16(alert_mask_ff, wr_data16, i_avs_byteenable[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan-all sequencer: one adc request per input, in order

  always @*
  begin
    nxt_state = state_ff;
    nxt_chan  = chan_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_scan)
        begin
          nxt_state = ST_REQ;
          nxt_chan  = `CH_FIRST;
        end
      end
      ST_REQ:
        nxt_state = ST_WAIT;
      ST_WAIT:
      begin
        if (i_adc_done)
          nxt_state = ST_EVAL;
      end
      ST_EVAL:
      begin
        if (chan_ff == `CH_LAST)
          nxt_state = ST_IDLE;
        else
        begin
          nxt_state = ST_REQ;
          nxt_chan  = chan_ff + 1'b1;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_ff      <= ST_IDLE;
      chan_ff       <= `CH_FIRST;
      o_adc_req     <= 1'b0;
      o_adc_channel <= `CH_FIRST;
    end
    else
    begin
      state_ff      <= nxt_state;
      chan_ff       <= nxt_chan;
      o_adc_req     <= (nxt_state == ST_REQ);
      o_adc_channel <= nxt_chan;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-input sample capture and compare

  assign limit[0] = {temp_threshold_ff[`TH_CHG_HI:`TH_CHG_LO], `LIMIT_PAD};
  assign limit[1] = {temp_threshold_ff[`TH_DIS_HI:`TH_DIS_LO], `LIMIT_PAD};

  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1)
    begin : g_ch
      always @(posedge i_clk_sys)
      begin
        if (i_reset)
        begin
          code_ff[g]         <= {`CODE_W{1'b0}};
          sample_valid_ff[g] <= 1'b0;
        end
        else
        begin
          sample_valid_ff[g] <= (state_ff == ST_WAIT) & i_adc_done & (chan_ff == g);
          if ((state_ff == ST_WAIT) & i_adc_done & (chan_ff == g))
            code_ff[g] <= i_adc_code;
        end
      end

      ot_compare u_cmp (
        .i_clk_sys      (i_clk_sys),
        .i_reset        (i_reset),
        .i_sample_valid (sample_valid_ff[g]),
        .i_code         (code_ff[g]),
        .i_limit        (limit[g]),
        .o_done_ff      (cmp_done[g]),
        .o_fault_ff     (cmp_fault[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, alert and switch outputs

  always @*
  begin
    nxt_chan_flag = chan_flag_ff;
    if (clear_all)
      nxt_chan_flag = {`NUM_CH{1'b0}};
    nxt_chan_flag = nxt_chan_flag | (cmp_fault & cmp_done);
  end

  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      chan_flag_ff              <= {`NUM_CH{1'b0}};
      o_alert                   <= 1'b0;
      o_charge_switch_enable    <= 1'b0;
      o_discharge_switch_enable <= 1'b0;
    end
    else
    begin
      chan_flag_ff              <= nxt_chan_flag;
      o_alert                   <= |(nxt_chan_flag & ~alert_mask_ff[`NUM_CH-1:0]);
      o_charge_switch_enable    <= fet_control_ff[`FC_CHG_EN_BIT];
      o_discharge_switch_enable <= fet_control_ff[`FC_DIS_EN_BIT];
    end
  end

endmodule // external_overtemp_detect

// ==== verification/adc_model.sv ====
`timescale 1ns/1ps
`include "overtemp_regs.vh"

module adc_model (
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset,
  input  wire logic               i_req,
  input  wire logic [`CH_W-1:0]   i_channel,
  input  wire logic [7:0]         i_code0,
  input  wire logic [7:0]         i_code1,
  input  wire logic [3:0]         i_wait,
  output logic                    o_done,
  output logic [`CODE_W-1:0]      o_code
);
  logic       busy;
  logic       sel;
  logic [3:0] cnt;
  // code line toggles outside the done cycle
  always @(posedge i_clk_sys)
  begin
    o_done <= 1'b0;
    o_code <= ~o_code;
    if (i_reset)
    begin
      busy   <= 1'b0;
      o_code <= 8'h5a;
    end
    else if (i_req)
    begin
      busy <= 1'b1;
      cnt  <= i_wait;
      sel  <= i_channel;
    end
    else if (busy && cnt == 4'h0)
    begin
      busy   <= 1'b0;
      o_done <= 1'b1;
      o_code <= sel ? i_code1 : i_code0;
    end
    else if (busy)
      cnt <= cnt - 4'h1;
  end
endmodule // adc_model

// ==== verification/external_overtemp_detect_properties.sv ====
`timescale 1ns/1ps
`include "overtemp_regs.vh"

module external_overtemp_detect_properties (
  input wire logic               i_clk_sys,
  input wire logic               i_reset,
  input wire logic [11:0]        i_avs_address,
  input wire logic               i_avs_write,
  input wire logic               i_avs_read,
  input wire logic [31:0]        i_avs_writedata,
  input wire logic [3:0]         i_avs_byteenable,
  input wire logic [31:0]        o_avs_readdata,
  input wire logic               o_avs_waitrequest,
  input wire logic               o_adc_req,
  input wire logic [`CH_W-1:0]   o_adc_channel,
  input wire logic               i_adc_done,
  input wire logic               o_alert,
  input wire logic               o_charge_switch_enable,
  input wire logic               o_discharge_switch_enable
);
  logic wait_ff;
  logic pend_ff;
  wire  take  = (i_avs_write || i_avs_read) && o_avs_waitrequest;
  wire  start = i_avs_write && !o_avs_waitrequest && i_avs_address == 12'h214 && i_avs_writedata[0]
                && i_avs_byteenable[0] && !pend_ff;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////
  always @(posedge i_clk_sys)
  begin
    wait_ff <= i_reset ? 1'b0 : o_adc_req ? 1'b1 : i_adc_done ? 1'b0 : wait_ff;
    pend_ff <= i_reset ? 1'b0 : start ? 1'b1 : (i_adc_done && wait_ff && o_adc_channel) ? 1'b0 : pend_ff;
  end
  ////////////////////////////////////////////////////////////
  bus_answer_a: assert property (take |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("late answer");
  rd_upper_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000) else $error("upper");
  reset_out_a: assert property (disable iff (1'b0) i_reset |=> o_avs_waitrequest && !o_alert && !o_adc_req
    && !o_charge_switch_enable && !o_discharge_switch_enable) else $error("reset outputs");
  scan_first_a: assert property (start |=> o_adc_req && o_adc_channel == 1'b0) else $error("no req");
  scan_second_a: assert property (i_adc_done && wait_ff && o_adc_channel == 1'b0 |-> !o_adc_req [*2]
    ##1 (o_adc_req && o_adc_channel == 1'b1)) else $error("no ch1 req");
  req_pulse_a: assert property (o_adc_req |=> !o_adc_req) else $error("req width");
  chan_hold_a: assert property (wait_ff |-> $stable(o_adc_channel) && !o_adc_req) else $error("chan moved");
  switch_follow_a: assert property (i_avs_write && !o_avs_waitrequest && i_avs_address == 12'h100
    && i_avs_byteenable[0] |-> ##2 o_charge_switch_enable == $past(i_avs_writedata[0], 2)
    && o_discharge_switch_enable == $past(i_avs_writedata[1], 2)) else $error("switch");
endmodule // external_overtemp_detect_properties

// ==== verification/external_overtemp_detect_tb.sv ====
`timescale 1ns/1ps
`include "overtemp_regs.vh"

module external_overtemp_detect_tb;
  logic              i_clk_sys = 1'b0, i_reset = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [11:0]       i_avs_address = 12'h000;
  logic [31:0]       i_avs_writedata = 32'h0000_0000, q;
  logic [3:0]        adc_wait = 4'h0;
  logic [3:0]        i_avs_byteenable = 4'h3;
  logic [7:0]        code0 = 8'h00, code1 = 8'h00;
  wire  [31:0]       o_avs_readdata;
  wire               o_avs_waitrequest, o_adc_req, i_adc_done, o_alert, o_chg, o_dis;
  wire  [`CH_W-1:0]  o_adc_channel;
  wire  [7:0]        i_adc_code;
  int                n_fail = 0, tests_run = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  external_overtemp_detect uut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_adc_req(o_adc_req), .o_adc_channel(o_adc_channel), .i_adc_done(i_adc_done), .i_adc_code(i_adc_code),
    .o_alert(o_alert), .o_charge_switch_enable(o_chg), .o_discharge_switch_enable(o_dis));
  adc_model adc (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(o_adc_req), .i_channel(o_adc_channel),
    .i_code0(code0), .i_code1(code1), .i_wait(adc_wait), .o_done(i_adc_done), .o_code(i_adc_code));
  ////////////////////////////////////////////////////////////
  task test_done;
  begin
    $display("failures %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // one held Avalon access, q takes read data at the accept edge
  task acc(input logic wr, input logic [11:0] a, input logic [15:0] d);
  begin
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_writedata <= {16'h0000, d};
    i_avs_write <= wr;
    i_avs_read <= !wr;
    @(posedge i_clk_sys);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_clk_sys);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  end
  endtask
  task scan(input logic [15:0] thr, input logic [15:0] msk, input logic [7:0] c0, input logic [7:0] c1);
  begin
    acc(1'b1, 12'h100, 16'h0040);
    acc(1'b1, 12'h20C, thr);
    acc(1'b1, 12'h210, msk);
    code0 <= c0;
    code1 <= c1;
    adc_wait <= adc_wait ^ 4'h5;
    acc(1'b1, 12'h214, 16'h0001);
    q = 32'h0000_0001;
    while (q[0] !== 1'b0) acc(1'b0, 12'h214, 16'h0000);
    repeat (3) @(posedge i_clk_sys);
  end
  endtask
  ////////////////////////////////////////////////////////////
  task t_reset;
  begin
    chk({o_alert, o_chg, o_dis, o_avs_waitrequest}, 32'h0000_0001);
    acc(1'b0, 12'h210, 16'h0000);
    chk(q, 32'h0000_0003);
    acc(1'b0, 12'h20C, 16'h0000);
    chk(q, 32'h0000_0000);
    acc(1'b0, 12'h3FC, 16'h0000);
    chk(q, 32'h0000_0000);
    acc(1'b0, 12'h041, 16'h0000);
    chk(q, 32'h0000_0000);
  end
  endtask
  task t_fet;
  begin
    acc(1'b1, 12'h100, 16'h0003);
    repeat (2) @(posedge i_clk_sys);
    chk({o_chg, o_dis}, 32'h0000_0003);
    acc(1'b1, 12'h100, 16'h0002);
    repeat (2) @(posedge i_clk_sys);
    chk({o_chg, o_dis}, 32'h0000_0001);
    // high lane only: switch bits must keep their value
    i_avs_byteenable <= 4'h2;
    acc(1'b1, 12'h100, 16'h0001);
    i_avs_byteenable <= 4'h3;
    acc(1'b0, 12'h100, 16'h0000);
    chk(q, 32'h0000_0002);
  end
  endtask
  task t_detect;
  begin
    scan(16'h0038, 16'h0000, 8'hDF, 8'h00);
    chk(q[9:8], 32'h0000_0001);
    chk(o_alert, 32'h0000_0001);
    acc(1'b0, 12'h218, 16'h0000);
    chk(q, 32'h0000_00DF);
    acc(1'b1, 12'h100, 16'h0003);
    acc(1'b0, 12'h040, 16'h0000);
    chk(q[4], 32'h0000_0001);
    chk({o_chg, o_dis}, 32'h0000_0003);
    // host reaction: flag seen, switches off
    if (q[4] === 1'b1)
      acc(1'b1, 12'h100, 16'h0000);
    repeat (2) @(posedge i_clk_sys);
    chk({o_chg, o_dis}, 32'h0000_0000);
    scan(16'h3800, 16'h0000, 8'h00, 8'hE0);
    chk(q[9:8], 32'h0000_0000);
    chk(o_alert, 32'h0000_0000);
    scan(16'h3800, 16'h0000, 8'h00, 8'hDF);
    chk(q[9:8], 32'h0000_0002);
    scan(16'h1800, 16'h0000, 8'h00, 8'h5F);
    chk(q[9:8], 32'h0000_0002);
  end
  endtask
  task t_mask;
  begin
    scan(16'h0038, 16'h0003, 8'h10, 8'h10);
    chk(q[9:8], 32'h0000_0001);
    chk(o_alert, 32'h0000_0000);
    scan(16'h3800, 16'h0001, 8'h10, 8'h10);
    chk(o_alert, 32'h0000_0001);
  end
  endtask
  task t_forced;
  begin
    scan(16'h3838, 16'h0000, 8'h80, 8'h80);
    chk(q[9:8], 32'h0000_0003);
    acc(1'b1, 12'h100, 16'h0040);
    acc(1'b0, 12'h040, 16'h0000);
    chk({q[4], o_alert}, 32'h0000_0000);
    scan(16'h0000, 16'h0000, 8'h80, 8'h80);
    chk(q[9:8], 32'h0000_0000);
  end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    n_fail++;
    test_done;
  end
  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_reset;
    t_fet;
    t_detect;
    t_mask;
    t_forced;
    test_done;
  end
endmodule // external_overtemp_detect_tb

bind external_overtemp_detect external_overtemp_detect_properties chk_i (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_avs_address(i_avs_address), .i_avs_write(i_avs_write), .i_avs_read(i_avs_read),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_adc_req(o_adc_req), .o_adc_channel(o_adc_channel),
  .i_adc_done(i_adc_done), .o_alert(o_alert), .o_charge_switch_enable(o_charge_switch_enable),
  .o_discharge_switch_enable(o_discharge_switch_enable));
